// ---- fspc_defs.vh ----
// Constants for the fan speed profile controller: register offsets,
// reset values, field positions and timing counts.
// Assumes a 125 MHz core clock; included by the core and its bench.
`ifndef FSPC_DEFS_VH
`define FSPC_DEFS_VH

// Register offsets on the serial register port
`define FSPC_A_MIN_OUT   15'h0100
`define FSPC_A_MAX_OUT   15'h0101
`define FSPC_A_MIN_THR   15'h0102
`define FSPC_A_MAX_THR   15'h0103
`define FSPC_A_LEAD_MAG  15'h0104
`define FSPC_A_TOP_W     15'h0105
`define FSPC_A_TAIL_W    15'h0106
`define FSPC_A_RAMP_CFG  15'h0107
`define FSPC_A_LEAD_CFG  15'h0108

// Reset values
`define FSPC_RST_MIN_OUT  8'h00
`define FSPC_RST_MAX_OUT  8'hFE
`define FSPC_RST_MIN_THR  8'h00
`define FSPC_RST_MAX_THR  8'hFF
`define FSPC_RST_LEAD_MAG 8'h90
`define FSPC_RST_TOP_W    8'h8F
`define FSPC_RST_TAIL_W   8'h8F
`define FSPC_RST_RAMP_CFG 8'h56
`define FSPC_RST_LEAD_CFG 8'hA5

// Field positions
`define FSPC_F_CODE7     7:1
`define FSPC_F_CODE6     6:1
`define FSPC_F_FAST      7:4
`define FSPC_F_SLOW      3:0
`define FSPC_F_RAMP      7:6
`define FSPC_F_TACH      5:4
`define FSPC_B_LOCK_POL  3
`define FSPC_B_SS_END    2
`define FSPC_F_SS_TIME   1:0
`define FSPC_B_SIGN_FAST 7
`define FSPC_B_SIGN_SLOW 6
`define FSPC_B_STEP_SEL  5
`define FSPC_B_SLOPE_INV 4
`define FSPC_B_BELOW_SEL 3
`define FSPC_B_ABOVE_SEL 2

// Output duty scale: 9 bits, one step is about 0.2 percent
`define FSPC_DUTY_FULL   9'h1FF
`define FSPC_CODE_FULL   7'h7E
`define FSPC_SS_END_LO   9'h07B
`define FSPC_SS_END_HI   9'h114
`define FSPC_LEAD_BIAS   10'h020

// Timing
`define FSPC_CLK_NS      8
`define FSPC_FG_PULSE_NS 1000
`define FSPC_FG_PULSE_CYC ((`FSPC_FG_PULSE_NS + `FSPC_CLK_NS - 1) / `FSPC_CLK_NS)

`endif

// ---- fspc_core.v ----
// Fan speed profile controller: parameter registers on a serial port and
// the duty map, lead angle, soft switch, ramp, soft start and tach logic.
// Assumes all pin inputs synchronous to clock; in_duty arrives with a
// one-cycle in_pulse per input PWM period from a measurement stage.
`timescale 1ns/10ps
`default_nettype none
`include "fspc_defs.vh"
module fspc_core #(
   parameter [19:0] SS_STEP0 = 20'd10000, // Soft start cycles per duty step, code 00
   parameter [19:0] SS_STEP1 = 20'd20000, // Code 01
   parameter [19:0] SS_STEP2 = 20'd40000, // Code 10
   parameter [19:0] SS_STEP3 = 20'd80000  // Code 11
)(
   input  wire       clock,
   input  wire       rst_n,
   input  wire       ce,
   input  wire       sclk,
   input  wire       cs_n,
   input  wire       mosi,
   output reg        miso,
   output reg        miso_oe,
   input  wire [7:0] in_duty,
   input  wire       in_pulse,
   input  wire       hall_in,
   input  wire       lock_active,
   input  wire       run_start,
   output reg  [8:0] out_duty,
   output reg        full_soft,
   output reg        ss_active,
   output reg  [6:0] lead_angle,
   output reg  [3:0] top_width,
   output reg  [3:0] tail_width,
   output reg        speed_pulse_out
);
   // Parameter registers
   reg [7:0]  min_out_r;      // Minimum output target
   reg [7:0]  max_out_r;      // Maximum output target
   reg [7:0]  min_thr_r;      // Minimum input threshold
   reg [7:0]  max_thr_r;      // Maximum input threshold
   reg [7:0]  lead_mag_r;     // Lead magnitudes, fast high nibble
   reg [7:0]  top_w_r;        // Soft switch top widths
   reg [7:0]  tail_w_r;       // Soft switch tail widths
   reg [7:0]  ramp_cfg_r;     // Ramp, tach, soft start
   reg [7:0]  lead_cfg_r;     // Lead signs, step size, slope and zones
   // Serial port state
   reg        sclk_d_r;       // Previous serial clock level
   reg [4:0]  bit_cnt_r;      // Bits seen in this frame
   reg [15:0] hdr_r;          // Read flag and address
   reg [7:0]  wsh_r;          // Write data shifter
   reg [7:0]  rsh_r;          // Read data shifter
   reg [7:0]  rd_data;        // Read mux result
   wire       sclk_rise = sclk & ~sclk_d_r;
   wire       sclk_fall = ~sclk & sclk_d_r;
   wire [14:0] cur_addr = {hdr_r[13:0], mosi};
   wire       wr_en = ce & ~cs_n & sclk_rise & (bit_cnt_r == 5'd23) & ~hdr_r[15];
   wire [7:0] wr_data = {wsh_r[6:0], mosi};
   // Read mux; fixed bits read at their held values, unmapped reads zero
   always @* begin
      case (cur_addr)
         `FSPC_A_MIN_OUT:  rd_data = {min_out_r[`FSPC_F_CODE7], 1'b0};
         `FSPC_A_MAX_OUT:  rd_data = {max_out_r[`FSPC_F_CODE7], 1'b0};
         `FSPC_A_MIN_THR:  rd_data = {1'b0, min_thr_r[`FSPC_F_CODE6], 1'b0};
         `FSPC_A_MAX_THR:  rd_data = {1'b1, max_thr_r[`FSPC_F_CODE6], 1'b1};
         `FSPC_A_LEAD_MAG: rd_data = lead_mag_r;
         `FSPC_A_TOP_W:    rd_data = top_w_r;
         `FSPC_A_TAIL_W:   rd_data = tail_w_r;
         `FSPC_A_RAMP_CFG: rd_data = ramp_cfg_r;
         `FSPC_A_LEAD_CFG: rd_data = lead_cfg_r;
         default:          rd_data = 8'h00;
      endcase
   end
   // Frame: read flag, 15 address bits, 8 data bits; mode 0 timing
   always @(posedge clock) begin
      if (!rst_n) begin
         sclk_d_r  <= 1'b0;
         bit_cnt_r <= 5'h00;
         hdr_r     <= 16'h0000;
         wsh_r     <= 8'h00;
         rsh_r     <= 8'h00;
         miso      <= 1'b0;
         miso_oe   <= 1'b0;
      end else if (ce) begin
         sclk_d_r <= sclk;
         if (cs_n) begin
            // Deselect aborts any partial frame
            bit_cnt_r <= 5'h00;
            miso_oe   <= 1'b0;
         end else begin
            miso_oe <= 1'b1;
            if (sclk_rise && bit_cnt_r != 5'd24) begin
               bit_cnt_r <= bit_cnt_r + 5'h01;
               if (bit_cnt_r < 5'd16)
                  hdr_r <= {hdr_r[14:0], mosi};
               else
                  wsh_r <= wr_data;
               if (bit_cnt_r == 5'd15)
                  rsh_r <= rd_data;
            end
            if (sclk_fall && bit_cnt_r >= 5'd16) begin
               // Shift out on falling edges so the host samples on rising
               miso  <= rsh_r[7];
               rsh_r <= {rsh_r[6:0], 1'b0};
            end
         end
      end
   end
   // Register writes; fixed bits are not stored as written
   always @(posedge clock) begin
      if (!rst_n) begin
         min_out_r  <= `FSPC_RST_MIN_OUT;
         max_out_r  <= `FSPC_RST_MAX_OUT;
         min_thr_r  <= `FSPC_RST_MIN_THR;
         max_thr_r  <= `FSPC_RST_MAX_THR;
         lead_mag_r <= `FSPC_RST_LEAD_MAG;
         top_w_r    <= `FSPC_RST_TOP_W;
         tail_w_r   <= `FSPC_RST_TAIL_W;
         ramp_cfg_r <= `FSPC_RST_RAMP_CFG;
         lead_cfg_r <= `FSPC_RST_LEAD_CFG;
      end else if (wr_en) begin
         case (hdr_r[14:0])
            `FSPC_A_MIN_OUT:  min_out_r  <= {wr_data[7:1], 1'b0};
            `FSPC_A_MAX_OUT:  max_out_r  <= {wr_data[7:1], 1'b0};
            `FSPC_A_MIN_THR:  min_thr_r  <= {1'b0, wr_data[6:1], 1'b0};
            `FSPC_A_MAX_THR:  max_thr_r  <= {1'b1, wr_data[6:1], 1'b1};
            `FSPC_A_LEAD_MAG: lead_mag_r <= wr_data;
            `FSPC_A_TOP_W:    top_w_r    <= wr_data;
            `FSPC_A_TAIL_W:   tail_w_r   <= wr_data;
            `FSPC_A_RAMP_CFG: ramp_cfg_r <= wr_data;
            `FSPC_A_LEAD_CFG: lead_cfg_r <= wr_data;
            default: ;
         endcase
      end
   end
   // Linear blend of a toward b by f/256; 255 lands on b exactly so the
   // top of the window gives the maximum-speed settings unrounded
   function [9:0] fspc_lerp;
      input [9:0] a;
      input [9:0] b;
      input [7:0] f;
      reg signed [19:0] p;
      begin
         p = ($signed({1'b0, b}) - $signed({1'b0, a})) * $signed({1'b0, f});
         fspc_lerp = (f == 8'hFF) ? b : a + p[17:8];
      end
   endfunction
   // Input duty window on an 8-bit scale
   wire [7:0] di = lead_cfg_r[`FSPC_B_SLOPE_INV] ? ~in_duty : in_duty;
   wire [7:0] thr_lo = {1'b0, min_thr_r[`FSPC_F_CODE6], 1'b0};
   wire [7:0] thr_hi = {1'b1, max_thr_r[`FSPC_F_CODE6], 1'b1};
   // Zone and speed fraction; the division is serial to save area
   localparam [1:0] ZN_MID = 2'b00;
   localparam [1:0] ZN_LOW = 2'b01;
   localparam [1:0] ZN_HIGH = 2'b10;
   reg [1:0] zone_r;          // Where the last input duty fell
   reg [7:0] frac_r;          // Position inside the window, 0..255
   reg [3:0] div_cnt_r;       // Division steps left
   reg [8:0] rem_r;           // Partial remainder
   reg [7:0] den_r;           // Window width
   reg [7:0] quo_r;           // Quotient being built
   wire [8:0] rem_sh = {rem_r[7:0], 1'b0};
   wire       q_bit = rem_sh >= {1'b0, den_r};
   always @(posedge clock) begin
      if (!rst_n) begin
         zone_r    <= ZN_LOW;
         frac_r    <= 8'h00;
         div_cnt_r <= 4'h0;
         rem_r     <= 9'h000;
         den_r     <= 8'h01;
         quo_r     <= 8'h00;
      end else if (ce) begin
         if (div_cnt_r != 4'h0) begin
            rem_r     <= q_bit ? rem_sh - {1'b0, den_r} : rem_sh;
            quo_r     <= {quo_r[6:0], q_bit};
            div_cnt_r <= div_cnt_r - 4'h1;
            if (div_cnt_r == 4'h1) begin
               frac_r <= {quo_r[6:0], q_bit};
               zone_r <= ZN_MID;
            end
         end else if (in_pulse) begin
            if (di < thr_lo) begin
               zone_r <= ZN_LOW;
               frac_r <= 8'h00;
            end else if (di > thr_hi) begin
               zone_r <= ZN_HIGH;
               frac_r <= 8'hFF;
            end else begin
               // Window width is at least 3, so no divide by zero
               rem_r     <= {1'b0, di - thr_lo};
               den_r     <= thr_hi - thr_lo;
               quo_r     <= 8'h00;
               div_cnt_r <= 4'h8;
            end
         end
      end
   end
   // Targets from codes; 126 and 127 both give full duty
   wire [8:0] tgt_min = (min_out_r[`FSPC_F_CODE7] >= `FSPC_CODE_FULL) ? `FSPC_DUTY_FULL
                        : {min_out_r[`FSPC_F_CODE7], 2'b00};
   wire [8:0] tgt_max = (max_out_r[`FSPC_F_CODE7] >= `FSPC_CODE_FULL) ? `FSPC_DUTY_FULL
                        : {max_out_r[`FSPC_F_CODE7], 2'b00};
   wire [9:0] tgt_mid = fspc_lerp({1'b0, tgt_min}, {1'b0, tgt_max}, frac_r);
   reg  [8:0] target;         // Duty the ramp moves toward
   always @* begin
      case (zone_r)
         ZN_LOW:  target = lead_cfg_r[`FSPC_B_BELOW_SEL] ? 9'h000 : tgt_min;
         ZN_HIGH: target = lead_cfg_r[`FSPC_B_ABOVE_SEL] ? `FSPC_DUTY_FULL : tgt_max;
         default: target = tgt_mid[8:0];
      endcase
   end
   // Signed lead angles held with a bias so the blend stays unsigned
   wire [3:0] mag_slow = lead_mag_r[`FSPC_F_SLOW];
   wire [3:0] mag_fast = lead_mag_r[`FSPC_F_FAST];
   wire [9:0] lead_slow = lead_cfg_r[`FSPC_B_SIGN_SLOW] ? `FSPC_LEAD_BIAS + mag_slow
                          : `FSPC_LEAD_BIAS - mag_slow;
   wire [9:0] lead_fast = lead_cfg_r[`FSPC_B_SIGN_FAST] ? `FSPC_LEAD_BIAS + mag_fast
                          : `FSPC_LEAD_BIAS - mag_fast;
   wire [9:0] lead_mix = fspc_lerp(lead_slow, lead_fast, frac_r) - `FSPC_LEAD_BIAS;
   wire [9:0] top_mix = fspc_lerp({6'h00, top_w_r[`FSPC_F_SLOW]},
                                  {6'h00, top_w_r[`FSPC_F_FAST]}, frac_r);
   wire [9:0] tail_mix = fspc_lerp({6'h00, tail_w_r[`FSPC_F_SLOW]},
                                   {6'h00, tail_w_r[`FSPC_F_FAST]}, frac_r);
   // Drive settings out; lead is in 0.35 degree units either way
   always @(posedge clock) begin
      if (!rst_n) begin
         lead_angle <= 7'h00;
         top_width  <= 4'h0;
         tail_width <= 4'h0;
         full_soft  <= 1'b0;
      end else if (ce) begin
         if (lead_cfg_r[`FSPC_B_STEP_SEL])
            lead_angle <= {lead_mix[5], lead_mix[5:0]};
         else
            lead_angle <= {lead_mix[5:0], 1'b0};
         top_width  <= top_mix[3:0];
         tail_width <= tail_mix[3:0];
         full_soft  <= (zone_r == ZN_HIGH) & lead_cfg_r[`FSPC_B_ABOVE_SEL];
      end
   end
   // Soft start step period and end duty
   reg  [19:0] ss_cnt_r;      // Cycles since the last soft start step
   reg  [9:0]  roc_cnt_r;     // Input pulses since the last ramp step
   reg  [19:0] ss_step;       // Selected cycles per step
   wire [8:0]  ss_end = ramp_cfg_r[`FSPC_B_SS_END] ? `FSPC_SS_END_HI : `FSPC_SS_END_LO;
   wire [9:0]  roc_lim = 10'h080 << ramp_cfg_r[`FSPC_F_RAMP];
   always @* begin
      case (ramp_cfg_r[`FSPC_F_SS_TIME])
         2'b00:   ss_step = SS_STEP0;
         2'b01:   ss_step = SS_STEP1;
         2'b10:   ss_step = SS_STEP2;
         default: ss_step = SS_STEP3;
      endcase
   end
   // Output duty: soft start first, then ramp toward the target
   always @(posedge clock) begin
      if (!rst_n) begin
         out_duty  <= 9'h000;
         ss_active <= 1'b1;
         ss_cnt_r  <= 20'h00000;
         roc_cnt_r <= 10'h000;
      end else if (ce) begin
         if (run_start) begin
            out_duty  <= 9'h000;
            ss_active <= 1'b1;
            ss_cnt_r  <= 20'h00000;
         end else if (ss_active) begin
            // Open-loop climb; the target is ignored until the end duty
            if (ss_cnt_r >= ss_step - 20'h00001) begin
               ss_cnt_r <= 20'h00000;
               if (out_duty >= ss_end)
                  ss_active <= 1'b0;
               else
                  out_duty <= out_duty + 9'h001;
            end else begin
               ss_cnt_r <= ss_cnt_r + 20'h00001;
            end
         end else if (ramp_cfg_r[`FSPC_F_RAMP] == 2'b11) begin
            out_duty <= target;
         end else if (in_pulse) begin
            if (roc_cnt_r >= roc_lim - 10'h001) begin
               roc_cnt_r <= 10'h000;
               if (out_duty < target)
                  out_duty <= out_duty + 9'h001;
               else if (out_duty > target)
                  out_duty <= out_duty - 9'h001;
            end else begin
               roc_cnt_r <= roc_cnt_r + 10'h001;
            end
         end
      end
   end
   // Tach pin
   localparam integer FG_PULSE = `FSPC_FG_PULSE_CYC; // Sliced to the counter where used
   reg       hall_d_r;        // Registered Hall level
   reg       half_r;          // Toggles once per Hall period
   reg [7:0] fg_cnt_r;        // Pulse stretch for the doubled rate
   always @(posedge clock) begin
      if (!rst_n) begin
         hall_d_r        <= 1'b0;
         half_r          <= 1'b0;
         fg_cnt_r        <= 8'h00;
         speed_pulse_out <= 1'b0;
      end else if (ce) begin
         hall_d_r <= hall_in;
         if (hall_in & ~hall_d_r)
            half_r <= ~half_r;
         // A fixed pulse per Hall edge doubles the rate; limits top speed
         if (hall_in ^ hall_d_r)
            fg_cnt_r <= FG_PULSE[7:0];
         else if (fg_cnt_r != 8'h00)
            fg_cnt_r <= fg_cnt_r - 8'h01;
         case (ramp_cfg_r[`FSPC_F_TACH])
            2'b00:   speed_pulse_out <= hall_d_r;
            2'b01:   speed_pulse_out <= fg_cnt_r != 8'h00;
            2'b10:   speed_pulse_out <= half_r;
            default: speed_pulse_out <= lock_active ^ ramp_cfg_r[`FSPC_B_LOCK_POL];
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- fspc_assertions.sv ----
// Port checker for fspc_core: serial port framing and soft start shape.
// Assumes one clock and synchronous active-low rst_n, bound to the core.
`timescale 1ns/10ps
`default_nettype none
module fspc_chk (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic       ce,
   input wire logic       cs_n,
   input wire logic       sclk,
   input wire logic       miso,
   input wire logic       miso_oe,
   input wire logic       run_start,
   input wire logic [8:0] out_duty,
   input wire logic       ss_active,
   input wire logic [6:0] lead_angle
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Leaving reset, soft start is armed at zero duty
   property p_rst; $rose(rst_n) |-> ss_active && out_duty == 9'h000; endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   // Select low drives miso one clock later
   property p_oe_on; ce && $fell(cs_n) |=> miso_oe; endproperty
   a_oe_on: assert property (p_oe_on) else $error("miso not driven");
   // Deselected port stops driving miso one clock later
   property p_oe_off; cs_n && $past(cs_n) |-> !miso_oe; endproperty
   a_oe_off: assert property (p_oe_off) else $error("miso driven idle");
   // Data moves only after a falling sclk, so it holds while sclk is high
   property p_miso_hold; !cs_n && sclk && $past(sclk) |-> $stable(miso); endproperty
   a_miso_hold: assert property (p_miso_hold) else $error("miso moved in high");
   // Soft start climbs one step at a time
   property p_ss_step;
      ss_active && !run_start ##1 ss_active |->
         out_duty == $past(out_duty) || out_duty == $past(out_duty) + 9'h001;
   endproperty
   a_ss_step: assert property (p_ss_step) else $error("soft start jump");
   // Soft start never ends below the lower end point
   property p_ss_end; $fell(ss_active) |-> $past(out_duty) >= 9'h07B; endproperty
   a_ss_end: assert property (p_ss_end) else $error("soft start ended low");
   // A restart request begins again from zero
   property p_restart; ce && run_start |=> ss_active && out_duty == 9'h000; endproperty
   a_restart: assert property (p_restart) else $error("restart ignored");
   // Outside reset, soft start is entered only through a restart request
   property p_ss_rise; $rose(ss_active) |-> $past(run_start); endproperty
   a_ss_rise: assert property (p_ss_rise) else $error("soft start unasked");
   // Fifteen steps of the coarse size bound the angle
   property p_lead; $signed(lead_angle) <= 7'sd30 && $signed(lead_angle) >= -7'sd30; endproperty
   a_lead: assert property (p_lead) else $error("lead out of range");
   c_ss_done: cover property ($fell(ss_active));
   c_read: cover property (miso_oe && sclk);
   c_restart: cover property (run_start);
endmodule
bind fspc_core fspc_chk u_chk (.clock(clock), .rst_n(rst_n), .ce(ce), .cs_n(cs_n),
   .sclk(sclk), .miso(miso), .miso_oe(miso_oe), .run_start(run_start),
   .out_duty(out_duty), .ss_active(ss_active), .lead_angle(lead_angle));
`default_nettype wire

// ---- fspc_host.sv ----
// Host model for the serial register port: R/W bit, address, data.
// Assumes the core samples sclk on the same clock; lo sets the pace.
`timescale 1ns/10ps
`default_nettype none
module fspc_host (
   input  wire logic clock,
   output var  logic sclk,
   output var  logic cs_n,
   output var  logic mosi,
   input  wire logic miso
);
   int lo = 3; // Low phase in clocks; 2 or more so miso has settled
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // One frame of nb bits, MSB first; read bits taken before each rise
   task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d,
                       input int nb, output logic [7:0] q);
      logic [23:0] f;
      f = {rd, a, d};
      q = 8'h00;
      @(posedge clock);
      cs_n <= 1'b0;
      for (int i = 0; i < nb; i++) begin
         mosi <= f[23 - i];
         repeat (lo) @(posedge clock);
         if (i > 15) q = {q[6:0], miso};
         sclk <= 1'b1;
         repeat (2) @(posedge clock);
         sclk <= 1'b0;
      end
      repeat (2) @(posedge clock);
      cs_n <= 1'b1;
      mosi <= ~mosi; // Released line shows no stale bit
      repeat (3) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// ---- fan_speed_profile_control_test.sv ----
// Self-checking bench for fspc_core: host model, duty pulses, Hall, lock.
// Assumes fspc_defs.vh offsets; soft start steps shortened to 2..5 clocks.
`timescale 1ns/10ps
`default_nettype none
`include "fspc_defs.vh"
module fan_speed_profile_control_test;
   logic       clock = 1'b0;
   logic       rst_n = 1'b0;
   logic       in_pulse = 1'b0;
   logic       hall_in = 1'b0;
   logic       lock_active = 1'b0;
   logic       run_start = 1'b0;
   logic       ce = 1'b1;
   logic [7:0] in_duty = 8'h00;
   wire        sclk, cs_n, mosi, miso, miso_oe, full_soft, ss_active, speed_pulse_out;
   wire  [8:0] out_duty;
   wire  [6:0] lead_angle;
   wire  [3:0] top_width, tail_width;
   int         n_errors = 0;
   int         check_count = 0;
   always #4 clock = ~clock; // 125 MHz
   fspc_host host (.clock(clock), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
   fspc_core #(.SS_STEP0(20'd2), .SS_STEP1(20'd3), .SS_STEP2(20'd4), .SS_STEP3(20'd5)) dut (
      .clock(clock), .rst_n(rst_n), .ce(ce), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
      .miso(miso), .miso_oe(miso_oe), .in_duty(in_duty), .in_pulse(in_pulse),
      .hall_in(hall_in), .lock_active(lock_active), .run_start(run_start),
      .out_duty(out_duty), .full_soft(full_soft), .ss_active(ss_active),
      .lead_angle(lead_angle), .top_width(top_width), .tail_width(tail_width),
      .speed_pulse_out(speed_pulse_out));
   // Case equality so an unknown never matches
   task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic rr(input logic [14:0] a, input logic [7:0] e);
      logic [7:0] q;
      host.xfer(1'b1, a, 8'h00, 24, q);
      chk("register", {2'b00, e}, {2'b00, q});
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] q;
      host.xfer(1'b0, a, d, 24, q);
   endtask
   // Spacing covers the 8-clock divider plus output latency
   task automatic pulse(input logic [7:0] d, input int n);
      repeat (n) begin
         in_duty <= d;
         in_pulse <= 1'b1;
         @(posedge clock);
         in_pulse <= 1'b0;
         repeat (15) @(posedge clock);
      end
   endtask
   task automatic duty(input logic [7:0] d, input logic [9:0] e);
      pulse(d, 1);
      chk("out_duty", e, {1'b0, out_duty});
   endtask
   task automatic tk(input logic e);
      repeat (4) @(posedge clock);
      chk("tach", {9'd0, e}, {9'd0, speed_pulse_out});
   endtask
   task automatic t_regs;
      logic [7:0] rv[9] = '{8'h00, 8'hFE, 8'h00, 8'hFF, 8'h90, 8'h8F, 8'h8F, 8'h56, 8'hA5};
      for (int i = 0; i < 9; i++)
         rr(`FSPC_A_MIN_OUT + 15'(i), rv[i]);
      wr(15'h0200, 8'h55);
      rr(15'h0200, 8'h00);
      wr(`FSPC_A_MIN_OUT, 8'hFF);
      rr(`FSPC_A_MIN_OUT, 8'hFE);
      wr(`FSPC_A_MIN_THR, 8'hFF);
      rr(`FSPC_A_MIN_THR, 8'h7E);
      wr(`FSPC_A_MAX_THR, 8'h00);
      rr(`FSPC_A_MAX_THR, 8'h81);
      host.lo = 6;
      host.xfer(1'b0, `FSPC_A_LEAD_MAG, 8'h11, 20, rv[0]);
      rr(`FSPC_A_LEAD_MAG, 8'h90);
      host.lo = 3;
      $display("test regs done");
   endtask
   // Every time code once, then the high end point
   task automatic t_ss;
      int n;
      int s;
      int e;
      for (int i = 0; i < 5; i++) begin
         s = (i < 4) ? i + 2 : 2;
         e = (i < 4) ? 123 : 276;
         wr(`FSPC_A_RAMP_CFG, (i < 4) ? 8'h40 + 8'(i) : 8'h44);
         run_start <= 1'b1;
         @(posedge clock);
         run_start <= 1'b0;
         @(posedge clock);
         n = 0;
         while (ss_active === 1'b1 && n < 3000) begin
            @(posedge clock);
            n++;
         end
         chk("ss_end", 10'(e), {1'b0, out_duty});
         chk("ss_len", 10'd1, {9'd0, n > (e - 2) * s && n < (e + 3) * s});
      end
      $display("test soft start done");
   endtask
   // Targets 64 and 128, window 40 to 129 on the input scale
   task automatic t_map;
      logic [8:0] v;
      wr(`FSPC_A_RAMP_CFG, 8'hC0);
      wr(`FSPC_A_MIN_OUT, 8'h20);
      wr(`FSPC_A_MAX_OUT, 8'h40);
      wr(`FSPC_A_MIN_THR, 8'h28);
      wr(`FSPC_A_MAX_THR, 8'h81);
      wr(`FSPC_A_LEAD_CFG, 8'h20);
      duty(8'd10, 10'd64);
      duty(8'd200, 10'd128);
      chk("full_soft", 10'd0, {9'd0, full_soft});
      pulse(8'd84, 1);
      v = out_duty;
      chk("mid", 10'd1, {9'd0, v >= 9'd94 && v <= 9'd97});
      wr(`FSPC_A_LEAD_CFG, 8'h24);
      duty(8'd200, 10'd511);
      chk("full_soft", 10'd1, {9'd0, full_soft});
      wr(`FSPC_A_LEAD_CFG, 8'h28);
      duty(8'd10, 10'd0);
      wr(`FSPC_A_LEAD_CFG, 8'h30);
      duty(8'd255, 10'd64);
      duty(8'd0, 10'd128);
      $display("test map done");
   endtask
   // Find one step, then count pulses to the next
   task automatic t_ramp;
      int n;
      logic [8:0] v;
      for (int c = 0; c < 3; c++) begin
         wr(`FSPC_A_RAMP_CFG, {2'(c), 6'h00});
         for (int k = 0; k < 2; k++) begin
            v = out_duty;
            n = 0;
            while (out_duty === v && n < 600) begin
               pulse(8'd255, 1);
               n++;
            end
         end
         chk("ramp_pulses", 10'(128 << c), 10'(n));
         chk("ramp_step", {1'b0, v} - 10'd1, {1'b0, out_duty});
      end
      $display("test ramp done");
   endtask
   task automatic t_lead;
      wr(`FSPC_A_LEAD_MAG, 8'h35);
      wr(`FSPC_A_TOP_W, 8'hA6);
      wr(`FSPC_A_TAIL_W, 8'h29);
      wr(`FSPC_A_LEAD_CFG, 8'h60);
      pulse(8'd10, 1);
      chk("lead", 10'h005, {3'b000, lead_angle});
      chk("top", 10'h006, {6'd0, top_width});
      chk("tail", 10'h009, {6'd0, tail_width});
      wr(`FSPC_A_LEAD_CFG, 8'h00);
      pulse(8'd10, 1);
      chk("lead", 10'h076, {3'b000, lead_angle});
      // Above the window the fast settings apply unblended
      pulse(8'd200, 1);
      chk("lead_fast", 10'h07A, {3'b000, lead_angle});
      chk("top_fast", 10'h00A, {6'd0, top_width});
      chk("tail_fast", 10'h002, {6'd0, tail_width});
      // Input 84 sits just under half way through the 40..129 window
      pulse(8'd84, 1);
      chk("top_mid", 10'd1, {9'd0, top_width >= 4'd7 && top_width <= 4'd8});
      chk("tail_mid", 10'd1, {9'd0, tail_width >= 4'd5 && tail_width <= 4'd6});
      $display("test lead done");
   endtask
   task automatic t_tach;
      logic v;
      wr(`FSPC_A_RAMP_CFG, 8'h38);
      lock_active <= 1'b1;
      tk(1'b0);
      lock_active <= 1'b0;
      tk(1'b1);
      wr(`FSPC_A_RAMP_CFG, 8'h30);
      lock_active <= 1'b1;
      tk(1'b1);
      wr(`FSPC_A_RAMP_CFG, 8'h00);
      ce <= 1'b0; // Frozen state must hide the Hall edge
      hall_in <= 1'b1;
      tk(1'b0);
      ce <= 1'b1;
      tk(1'b1);
      hall_in <= 1'b0;
      tk(1'b0);
      wr(`FSPC_A_RAMP_CFG, 8'h20);
      v = speed_pulse_out;
      hall_in <= 1'b1;
      tk(~v);
      hall_in <= 1'b0;
      tk(~v);
      wr(`FSPC_A_RAMP_CFG, 8'h10);
      hall_in <= 1'b1;
      tk(1'b1);
      repeat (126) @(posedge clock);
      tk(1'b0);
      $display("test tach done");
   endtask
   // Hang guard, well above the expected run length
   initial begin
      repeat (80000) @(posedge clock);
      n_errors++;
      finish_test;
   end
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      t_regs;
      t_ss;
      t_map;
      t_ramp;
      t_lead;
      t_tach;
      finish_test;
   end
endmodule
`default_nettype wire
